// ---- verilog/acso_regs.svh ----
`ifndef ACSO_REGS_SVH
`define ACSO_REGS_SVH

// ==========================================================================
// Word layout
// ==========================================================================
// Bits in one conversion word.
`define ACSO_WORD_BITS 24
// Index of the most significant bit of a word.
`define ACSO_MSB 23
// Last bit count of a complete read.
`define ACSO_LAST_BIT 5'h17

// ==========================================================================
// Reset and saturation values
// ==========================================================================
// Synchroniser reset: trigger, sleep and chip select sit inactive (high).
`define ACSO_SYNC_RST 8'h38
// Full scale word used when a unipolar result saturates high.
`define ACSO_FULL_SCALE 24'hffffff

// ==========================================================================
// Timing counts
// ==========================================================================
// Period of the block clock, in ns.
`define ACSO_CLK_NS 4
// Period of the on-chip oscillator, in ns.
`define ACSO_OSC_NS 32
// Oscillator divider, in block clock cycles.
`define ACSO_OSC_DIV (`ACSO_OSC_NS / `ACSO_CLK_NS)
// Master clock pin quiet this long counts as tied, in ns.
`define ACSO_MCLK_IDLE_NS 1000
// The same quiet time in block clock cycles (rounded down).
`define ACSO_MCLK_IDLE_CYC (`ACSO_MCLK_IDLE_NS / `ACSO_CLK_NS)
// Master clock cycles from trigger to finished word.
`define ACSO_SAMPLE_TRIGGER_N_TICKS 1182
// Master clock cycles of the reset sequence.
`define ACSO_RST_TICKS 16
// Ready rises this many master clock cycles before new data.
`define ACSO_EARLY_TICKS 2

`endif

// ---- verilog/acso_pkg.sv ----
`default_nettype none
// ==========================================================================
// Shared types
// ==========================================================================
package acso_pkg;
	// Conversion sequencer states.
	typedef enum logic [1:0] {
		ST_RST,
		ST_IDLE,
		ST_SAMPLE_TRIGGER_N,
		ST_HOLD
	} acso_state_t;
endpackage : acso_pkg
`default_nettype wire

// ---- verilog/acso_skid.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "acso_regs.svh"
// ==========================================================================
// Two-entry word buffer
// ==========================================================================
module acso_skid
	import acso_pkg::*;
#(
	parameter int W = `ACSO_WORD_BITS
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	input  wire logic         i_ce,
	input  wire logic         i_valid,
	output logic              o_ready,
	input  wire logic [W-1:0] i_data,
	output logic              o_valid,
	input  wire logic         i_ready,
	output logic      [W-1:0] o_data
);
	logic [W-1:0] mem_r [0:1];  // Two storage entries.
	logic         wr_ptr_r;     // Next entry to fill.
	logic         rd_ptr_r;     // Next entry to drain.
	logic [1:0]   cnt_r;        // Entries in use.
	logic         push;         // Word accepted this cycle.
	logic         pop;          // Word taken this cycle.

	// Full and empty come straight from the fill count.
	assign o_ready = (cnt_r != 2'h2);
	assign o_valid = (cnt_r != 2'h0);
	assign o_data  = mem_r[rd_ptr_r];
	assign push    = i_valid & o_ready;
	assign pop     = o_valid & i_ready;

	// Storage write, one entry per push.
	always_ff @(posedge i_clk) begin
		if (i_ce && push) begin
			mem_r[wr_ptr_r] <= i_data;
		end
	end

	// Pointers and fill count.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wr_ptr_r <= 1'b0;
			rd_ptr_r <= 1'b0;
			cnt_r    <= 2'h0;
		end else if (i_ce) begin
			if (push) begin
				wr_ptr_r <= ~wr_ptr_r;
			end
			if (pop) begin
				rd_ptr_r <= ~rd_ptr_r;
			end
			cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule : acso_skid
`default_nettype wire

// ---- verilog/acso_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "acso_regs.svh"
module acso_top
	import acso_pkg::*;
#(
	parameter int P_SAMPLE_TRIGGER_N_TICKS = `ACSO_SAMPLE_TRIGGER_N_TICKS,
	parameter int P_RST_TICKS  = `ACSO_RST_TICKS
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_ce,
	input  wire logic        i_reset_n,
	input  wire logic        i_sleep_n,
	input  wire logic        i_sample_trigger_n,
	input  wire logic        i_polarity_select,
	input  wire logic        i_port_role_select,
	input  wire logic        i_cs_n,
	input  wire logic        i_mclk,
	input  wire logic        i_sclk,
	input  wire logic [23:0] i_filter_data,
	output logic             o_sclk,
	output logic             o_sclk_oe,
	output logic             o_serial_result_out,
	output logic             o_serial_result_oe,
	output logic             o_ready_n,
	output logic             o_analog_pd,
	output logic             o_osc_running,
	output logic             o_sample_trigger_n_busy
);
	// ======================================================================
	// Pin synchronisers
	// ======================================================================
	logic [7:0]  pins;        // Raw pins, one bit each.
	logic [7:0]  s1_r;        // First stage, read only by the second.
	logic [7:0]  s2_r;        // Second stage, safe to use.
	logic        mclk_s;      // Master clock pin, synchronised.
	logic        sclk_s;      // Host shift clock, synchronised.
	logic        cs_n_s;      // Chip select, synchronised.
	logic        trig_n_s;    // Conversion trigger, synchronised.
	logic        sleep_n_s;   // Sleep pin, synchronised.
	logic        reset_n_s;   // Reset pin, synchronised.
	logic        pol_s;       // Polarity select, synchronised.
	logic        role_s;      // Port role select, synchronised.
	logic        rst_all;     // Reset of all block state except the pin synchronisers.
	// Reset levels of the synchroniser, one bit per pin.
	localparam logic [7:0] SYNC_RST = `ACSO_SYNC_RST;

	assign pins = {i_mclk, i_sclk, i_cs_n, i_sample_trigger_n,
		i_sleep_n, i_reset_n, i_polarity_select, i_port_role_select};
	assign {mclk_s, sclk_s, cs_n_s, trig_n_s,
		sleep_n_s, reset_n_s, pol_s, role_s} = s2_r;

	// two flops per pin
	// Two flip-flops per pin before any logic looks at it.
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_sync
			always_ff @(posedge i_clk) begin
				if (i_rst) begin
					s1_r[g] <= SYNC_RST[g];
					s2_r[g] <= SYNC_RST[g];
				end else if (i_ce) begin
					s1_r[g] <= pins[g];
					s2_r[g] <= s1_r[g];
				end
			end
		end
	endgenerate

	assign rst_all = i_rst | ~reset_n_s;

	// ======================================================================
	// Master clock selection
	// ======================================================================
	logic        mclk_d_r;    // Master clock pin, one cycle later.
	logic        sclk_d_r;    // Host shift clock, one cycle later.
	logic [7:0]  idle_cnt_r;  // Cycles since the last master pin edge.
	logic [3:0]  osc_cnt_r;   // On-chip oscillator divider.
	logic        mclk_idle;   // Master pin has stopped toggling.
	logic        osc_mode;    // Pin tied low: oscillator runs while awake.
	logic        mclk_stop;   // Pin held high: every clock stops.
	logic        tick;        // One master clock period has passed.

	assign mclk_idle = (idle_cnt_r == 8'(`ACSO_MCLK_IDLE_CYC));
	assign osc_mode  = mclk_idle & ~mclk_s;
	assign mclk_stop = mclk_idle & mclk_s;
	assign o_osc_running = osc_mode & sleep_n_s;
	assign o_analog_pd   = ~sleep_n_s;
	assign tick = (~mclk_idle & mclk_s & ~mclk_d_r)
		| (o_osc_running & (osc_cnt_r == 4'h0));

	// Edge history of the master and shift clock pins, and quiet-time watch on the master pin.
	always_ff @(posedge i_clk) begin
		if (rst_all) begin
			mclk_d_r   <= 1'b0;
			sclk_d_r   <= 1'b0;
			idle_cnt_r <= 8'h00;
		end else if (i_ce) begin
			mclk_d_r <= mclk_s;
			sclk_d_r <= sclk_s;
			if (mclk_s != mclk_d_r) begin
				idle_cnt_r <= 8'h00;
			end else if (!mclk_idle) begin
				idle_cnt_r <= idle_cnt_r + 8'h01;
			end
		end
	end

	// Oscillator divider, frozen unless the oscillator may run.
	always_ff @(posedge i_clk) begin
		if (rst_all) begin
			osc_cnt_r <= 4'h0;
		end else if (i_ce && o_osc_running) begin
			if (osc_cnt_r == 4'(`ACSO_OSC_DIV - 1)) begin
				osc_cnt_r <= 4'h0;
			end else begin
				osc_cnt_r <= osc_cnt_r + 4'h1;
			end
		end
	end

	// ======================================================================
	// Conversion sequencer
	// ======================================================================
	acso_state_t state_r;     // Sequencer state.
	logic [11:0] sample_trigger_n_cnt_r;  // Master clock cycles counted.
	logic [23:0] word_r;      // Coded result waiting for the buffer.
	logic        start_ok;    // Trigger low and awake.
	logic        sample_trigger_n_last;   // Last master cycle of a conversion.
	logic        early;       // Moment to raise ready ahead of data.
	logic        buf_in_rdy;  // Buffer has room.
	logic        buf_valid;   // Buffer holds a word.
	logic [23:0] buf_data;    // Oldest buffered word.
	logic        load;        // Word moves into the output register.
	logic        reading_r;   // A read of the port is under way.

	assign start_ok  = ~trig_n_s & sleep_n_s;
	assign sample_trigger_n_last = tick & (sample_trigger_n_cnt_r == 12'(P_SAMPLE_TRIGGER_N_TICKS - 1));
	assign early = tick & ~reading_r & (state_r == ST_SAMPLE_TRIGGER_N)
		& (sample_trigger_n_cnt_r == 12'(P_SAMPLE_TRIGGER_N_TICKS - 1 - `ACSO_EARLY_TICKS));
	assign o_sample_trigger_n_busy = (state_r == ST_SAMPLE_TRIGGER_N);

	// Output coding of a finished result.
	function automatic logic [23:0] acso_code(
		input logic [23:0] d,
		input logic        bp
	);
		logic [23:0] c;
		if (bp) begin
			c = d;
		end else if (d[`ACSO_MSB]) begin
			c = 24'h000000;
		end else if (d[22]) begin
			c = `ACSO_FULL_SCALE;
		end else begin
			c = {d[22:0], 1'b0};
		end
		return c;
	endfunction : acso_code

	// Sequencer: reset wait, idle, converting, handing off.
	always_ff @(posedge i_clk) begin
		if (rst_all) begin
			state_r    <= ST_RST;
			sample_trigger_n_cnt_r <= 12'h000;
			word_r     <= 24'h000000;
		end else if (i_ce) begin
			unique case (state_r)
				// Count out the reset sequence in master cycles.
				ST_RST: begin
					if (tick) begin
						sample_trigger_n_cnt_r <= sample_trigger_n_cnt_r + 12'h001;
					end
					if (tick && sample_trigger_n_cnt_r == 12'(P_RST_TICKS - 1)) begin
						state_r    <= ST_IDLE;
						sample_trigger_n_cnt_r <= 12'h000;
					end
				end
				ST_IDLE: begin
					if (start_ok) begin
						state_r    <= ST_SAMPLE_TRIGGER_N;
						sample_trigger_n_cnt_r <= 12'h000;
					end
				end
				// Running; later triggers are ignored here.
				ST_SAMPLE_TRIGGER_N: begin
					if (!sleep_n_s) begin
						state_r <= ST_IDLE;
					end else if (sample_trigger_n_last) begin
						state_r <= ST_HOLD;
						word_r  <= acso_code(i_filter_data, pol_s);
					end else if (tick) begin
						sample_trigger_n_cnt_r <= sample_trigger_n_cnt_r + 12'h001;
					end
				end
				// Wait for room in the buffer.
				ST_HOLD: begin
					if (buf_in_rdy) begin
						state_r <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// ======================================================================
	// Word buffer between sequencer and port
	// ======================================================================
	acso_skid #(
		.W (`ACSO_WORD_BITS)
	) u_skid (
		.i_clk   (i_clk),
		.i_rst   (rst_all),
		.i_ce    (i_ce),
		.i_valid (state_r == ST_HOLD),
		.o_ready (buf_in_rdy),
		.i_data  (word_r),
		.o_valid (buf_valid),
		.i_ready (~reading_r),
		.o_data  (buf_data)
	);

	assign load = buf_valid & ~reading_r;

	// ======================================================================
	// Serial output port
	// ======================================================================
	logic [23:0] sreg_r;      // Output shift register.
	logic [4:0]  bit_cnt_r;   // Rising edges seen in this read.
	logic        sclk_r;      // Self-made shift clock.
	logic        host_rise;   // Host shift clock rising edge.
	logic        self_rise;   // Self-made shift clock rising edge.
	logic        shift;       // Advance one bit.
	logic        last_bit;    // This edge empties the port.

	assign host_rise = ~role_s & ~cs_n_s & sclk_s & ~sclk_d_r;
	assign self_rise = role_s & reading_r & tick & ~sclk_r;
	assign shift     = (host_rise | self_rise) & (reading_r | ~role_s);
	assign last_bit  = shift & (bit_cnt_r == `ACSO_LAST_BIT);

	assign o_sclk              = sclk_r;
	assign o_serial_result_out = sreg_r[`ACSO_MSB];
	assign o_serial_result_oe  = ~cs_n_s;
	assign o_sclk_oe           = role_s & ~cs_n_s;

	// Shift register and read tracking.
	always_ff @(posedge i_clk) begin
		if (rst_all) begin
			sreg_r    <= 24'h000000;
			// The port starts empty, so stray edges begin no read.
			bit_cnt_r <= 5'(`ACSO_WORD_BITS);
			reading_r <= 1'b0;
		end else if (i_ce) begin
			if (load) begin
				sreg_r    <= buf_data;
				bit_cnt_r <= 5'h00;
				reading_r <= role_s & ~cs_n_s;
			end else if (shift && bit_cnt_r <= `ACSO_LAST_BIT) begin
				sreg_r    <= {sreg_r[22:0], 1'b0};
				bit_cnt_r <= bit_cnt_r + 5'h01;
				reading_r <= ~last_bit;
			end
		end
	end

	// Self-made shift clock toggles once per master cycle.
	always_ff @(posedge i_clk) begin
		if (rst_all) begin
			sclk_r <= 1'b0;
		end else if (i_ce && tick && role_s && (reading_r || sclk_r)) begin
			sclk_r <= ~sclk_r;
		end
	end

	// ======================================================================
	// Ready flag
	// ======================================================================
	// Falls on each load; rises on empty, early warning or fresh start.
	always_ff @(posedge i_clk) begin
		if (rst_all) begin
			o_ready_n <= 1'b1;
		end else if (i_ce) begin
			if (load) begin
				o_ready_n <= 1'b0;
			end else if (state_r == ST_RST && tick
				&& sample_trigger_n_cnt_r == 12'(P_RST_TICKS - 1)) begin
				o_ready_n <= 1'b0;
			end else if (last_bit || early) begin
				o_ready_n <= 1'b1;
			end else if (state_r == ST_IDLE && start_ok && !reading_r) begin
				o_ready_n <= 1'b1;
			end
		end
	end

	// ======================================================================
	// Checks
	// ======================================================================
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (rst_all || !i_ce);

	property p_sdo_hiz;
		i_cs_n [*3] |-> !o_serial_result_oe;
	endproperty
	a_sdo_hiz: assert property (p_sdo_hiz)
		else $error("data output driven while deselected");

	property p_sclk_hiz;
		i_cs_n [*3] |-> !o_sclk_oe;
	endproperty
	a_sclk_hiz: assert property (p_sclk_hiz)
		else $error("shift clock driven while deselected");

	property p_master;
		(i_port_role_select && !i_cs_n) [*3] |-> o_sclk_oe;
	endproperty
	a_master: assert property (p_master)
		else $error("master role does not drive shift clock");

	property p_load;
		load |=> !o_ready_n && sreg_r == $past(buf_data);
	endproperty
	a_load: assert property (p_load)
		else $error("word load did not drop ready");

	property p_msb;
		shift && !load |=> sreg_r == {$past(sreg_r[22:0]), 1'b0};
	endproperty
	a_msb: assert property (p_msb)
		else $error("shift not MSB first");

	property p_empty;
		last_bit && !load |=> o_ready_n && !reading_r;
	endproperty
	a_empty: assert property (p_empty)
		else $error("ready low after word shifted out");

	property p_start;
		state_r == ST_IDLE && start_ok |=> state_r == ST_SAMPLE_TRIGGER_N;
	endproperty
	a_start: assert property (p_start)
		else $error("trigger did not start conversion");

	property p_bip;
		state_r == ST_SAMPLE_TRIGGER_N && sample_trigger_n_last && sleep_n_s && pol_s
			|=> word_r == $past(i_filter_data);
	endproperty
	a_bip: assert property (p_bip)
		else $error("bipolar word not two's complement");

	property p_early;
		early && !load |=> o_ready_n;
	endproperty
	a_early: assert property (p_early)
		else $error("ready not raised ahead of data");

	property p_stop;
		mclk_stop |-> !tick;
	endproperty
	a_stop: assert property (p_stop)
		else $error("master cycle while clocks stopped");

	property p_auto;
		load && role_s && !cs_n_s |=> reading_r ##[1:40] self_rise;
	endproperty
	a_auto: assert property (p_auto)
		else $error("self-clocked read did not begin");

	c_full_read: cover property (last_bit);
	c_overwrite: cover property (load && bit_cnt_r == 5'h00 && !o_ready_n);
	c_back2back: cover property (load && state_r == ST_IDLE && start_ok);
endmodule : acso_top
`default_nettype wire

// ---- tb/acso_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Host reader model
// ==========================================================================
module acso_host_model (
	input  wire logic        i_clk,
	input  wire logic        i_role,
	input  wire logic        i_sclk_dev,
	input  wire logic        i_sclk_dev_oe,
	input  wire logic        i_sdo,
	input  wire logic        i_sdo_oe,
	output logic             o_sclk,
	output logic      [23:0] o_word,
	output logic       [4:0] o_count
);
	logic sdo_w;     // Data pin level as the host sees it.
	logic sdo_last;  // Data pin level one cycle back.
	logic sclk_last; // Device shift clock one cycle back.

	// A released data pin shows a changing level, never a stale bit.
	assign sdo_w = i_sdo_oe ? i_sdo : ~sdo_last;

	initial begin
		o_sclk = 1'b0;
		o_count = 5'h00;
		sdo_last = 1'b0;
		sclk_last = 1'b0;
	end

	always @(negedge i_clk) begin
		if (i_role && i_sclk_dev_oe && i_sclk_dev && !sclk_last) begin
			o_word <= {o_word[22:0], sdo_last};
			o_count <= o_count + 5'h01;
		end
		sclk_last <= i_sclk_dev;
		sdo_last <= sdo_w;
	end

	// Restart the self-clocked bit count.
	task automatic clear();
		o_count = 5'h00;
	endtask : clear

	task automatic read_slave(output logic [23:0] w);
		for (int i = 0; i < 24; i++) begin
			@(negedge i_clk);
			w = {w[22:0], sdo_w};
			o_sclk = 1'b1;
			repeat (8) @(negedge i_clk);
			o_sclk = 1'b0;
			repeat (7) @(negedge i_clk);
		end
	endtask : read_slave
endmodule : acso_host_model
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
	n_errors++; $display("MISMATCH %s expected %h seen %h", nm, ex, got); \
	end end
// ==========================================================================
// Testbench top
// ==========================================================================
module testbench;
	localparam int SAMPLE_TRIGGER_N = 40; // Shortened conversion length in ticks.
	localparam int RSTT = 4;  // Shortened reset sequence in ticks.
	logic        clk, rst, reset_n, sleep_n, trig_n, pol, role, cs_n, mclk;
	logic        ext;      // External master clock running.
	logic  [1:0] mdiv;     // Master clock divider.
	logic [23:0] filt, w;  // Filter word and word read back.
	logic        sclk_o, sclk_oe, serial_result_out, sdo_oe, ready_n, pd, osc, sample_trigger_n_busy;
	logic        host_sclk, sclk_w;
	logic [23:0] host_word;
	logic  [4:0] host_cnt;
	int          n_errors, tests_run;
	logic [23:0] dat [4] = '{24'h812345, 24'h812345, 24'h400000, 24'h123456};
	logic        bpv [4] = '{1'b1, 1'b0, 1'b0, 1'b0};

	// The shift clock pin carries whichever party drives it.
	assign sclk_w = sclk_oe ? sclk_o : host_sclk;

	acso_top #(.P_SAMPLE_TRIGGER_N_TICKS(SAMPLE_TRIGGER_N), .P_RST_TICKS(RSTT)) acso_top_i (
		.i_clk(clk), .i_rst(rst), .i_ce(1'b1), .i_reset_n(reset_n),
		.i_sleep_n(sleep_n), .i_sample_trigger_n(trig_n),
		.i_polarity_select(pol), .i_port_role_select(role), .i_cs_n(cs_n),
		.i_mclk(mclk), .i_sclk(sclk_w), .i_filter_data(filt),
		.o_sclk(sclk_o), .o_sclk_oe(sclk_oe), .o_serial_result_out(serial_result_out),
		.o_serial_result_oe(sdo_oe), .o_ready_n(ready_n), .o_analog_pd(pd),
		.o_osc_running(osc), .o_sample_trigger_n_busy(sample_trigger_n_busy));

	acso_host_model acso_host_model_i (
		.i_clk(clk), .i_role(role), .i_sclk_dev(sclk_o),
		.i_sclk_dev_oe(sclk_oe), .i_sdo(serial_result_out), .i_sdo_oe(sdo_oe),
		.o_sclk(host_sclk), .o_word(host_word), .o_count(host_cnt));

	// Block clock, 4 ns period.
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	always @(negedge clk) begin
		if (ext) begin
			mdiv <= mdiv + 2'h1;
			if (mdiv == 2'h3) mclk <= ~mclk;
		end
	end

	// Prints the counts and the verdict, then stops.
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : conclude

	// Waits for ready (sel 0) or busy (sel 1) to reach a level.
	task automatic wait_sig(input logic sel, input logic lvl, input int lim);
		int n = 0;
		while (((sel ? sample_trigger_n_busy : ready_n) !== lvl) && n < lim) begin
			@(negedge clk);
			n++;
		end
		tests_run++;
		if (n >= lim) begin
			n_errors++;
			$display("MISMATCH wait expected %h seen timeout", lvl);
		end
	endtask : wait_sig

	// Pulses the trigger low with a filter word in place.
	task automatic start(input logic [23:0] d, input logic bp);
		@(negedge clk);
		filt = d;
		pol = bp;
		trig_n = 1'b0;
		repeat (5) @(negedge clk);
		trig_n = 1'b1;
	endtask : start

	// Word the port should carry for a filter word and coding.
	function automatic logic [23:0] exp_word(input logic [23:0] d,
		input logic bp);
		if (bp) return d;
		if (d[23]) return 24'h000000;
		if (d >= 24'h400000) return 24'hffffff;
		return {d[22:0], 1'b0};
	endfunction : exp_word

	// Watchdog well beyond the expected run length.
	initial begin
		#100000;
		n_errors++;
		conclude();
	end

	// Main sequence.
	initial begin
		n_errors = 0; tests_run = 0; rst = 1'b1; reset_n = 1'b1;
		sleep_n = 1'b1; trig_n = 1'b1; pol = 1'b1; role = 1'b0;
		cs_n = 1'b0; mclk = 1'b0; ext = 1'b0; mdiv = 2'h0; filt = 24'h0;
		repeat (3) @(negedge clk);
		`CHK("ready_n in reset", 1'b1, ready_n)
		rst = 1'b0;
		wait_sig(1'b0, 1'b0, 1500);
		`CHK("osc", 1'b1, osc)
		// Host-clocked reads in both codings.
		for (int k = 0; k < 4; k++) begin
			start(dat[k], bpv[k]);
			`CHK("ready_n sample_trigger_n", 1'b1, ready_n)
			`CHK("busy", 1'b1, sample_trigger_n_busy)
			wait_sig(1'b0, 1'b0, 800);
			acso_host_model_i.read_slave(w);
			`CHK("word", exp_word(dat[k], bpv[k]), w)
			repeat (4) @(negedge clk);
			`CHK("ready_n read", 1'b1, ready_n)
		end
		// A trigger during a conversion is not acted on.
		start(24'h0a0b0c, 1'b1);
		repeat (20) @(negedge clk);
		start(24'h0a0b0c, 1'b1);
		wait_sig(1'b0, 1'b0, 800);
		repeat (3) @(negedge clk);
		`CHK("busy ignored", 1'b0, sample_trigger_n_busy)
		// Held trigger, early ready and overwrite of an unread word.
		@(negedge clk);
		filt = 24'h111111;
		trig_n = 1'b0;
		wait_sig(1'b0, 1'b1, 10);
		wait_sig(1'b0, 1'b0, 800);
		filt = 24'h7edcba;
		repeat (2) @(negedge clk);
		`CHK("busy restart", 1'b1, sample_trigger_n_busy)
		trig_n = 1'b1;
		wait_sig(1'b0, 1'b1, 600);
		`CHK("busy early", 1'b1, sample_trigger_n_busy)
		wait_sig(1'b0, 1'b0, 40);
		acso_host_model_i.read_slave(w);
		`CHK("overwrite", 24'h7edcba, w)
		// Self-clocked read starts by itself.
		role = 1'b1;
		acso_host_model_i.clear();
		start(24'h9abcde, 1'b1);
		for (int n = 0; n < 2000 && host_cnt != 5'd24; n++) @(negedge clk);
		`CHK("self count", 5'd24, host_cnt)
		`CHK("self word", 24'h9abcde, host_word)
		repeat (12) @(negedge clk);
		`CHK("self ready_n", 1'b1, ready_n)
		`CHK("self sclk idle", 1'b0, sclk_o)
		`CHK("sclk oe sel", 1'b1, sclk_oe)
		cs_n = 1'b1;
		repeat (5) @(negedge clk);
		`CHK("sdo oe", 1'b0, sdo_oe)
		`CHK("sclk oe", 1'b0, sclk_oe)
		cs_n = 1'b0;
		role = 1'b0;
		repeat (5) @(negedge clk);
		`CHK("sclk oe slave", 1'b0, sclk_oe)
		// Sleep powers down and stops the oscillator.
		sleep_n = 1'b0;
		repeat (5) @(negedge clk);
		`CHK("pd", 1'b1, pd)
		`CHK("osc sleep", 1'b0, osc)
		sleep_n = 1'b1;
		repeat (5) @(negedge clk);
		`CHK("pd off", 1'b0, pd)
		// Master clock held high stops all clocks.
		mclk = 1'b1;
		repeat (300) @(negedge clk);
		`CHK("osc stopped", 1'b0, osc)
		start(24'h234567, 1'b1);
		repeat (400) @(negedge clk);
		`CHK("frozen", 1'b1, ready_n)
		ext = 1'b1;
		wait_sig(1'b0, 1'b0, 800);
		`CHK("osc ext", 1'b0, osc)
		ext = 1'b0;
		@(negedge clk);
		mclk = 1'b0;
		repeat (300) @(negedge clk);
		// Reset pin held low resets everything but the pin synchronisers.
		reset_n = 1'b0;
		repeat (6) @(negedge clk);
		`CHK("ready_n pin rst", 1'b1, ready_n)
		reset_n = 1'b1;
		wait_sig(1'b0, 1'b0, 1500);
		conclude();
	end
endmodule : testbench
`default_nettype wire
